// ---- common/ouhb_pkg.sv ----
// shared constants and types for the octal uart host bus port
package ouhb_pkg;
    localparam int unsigned NUM_CHAN       = 8;
    localparam int unsigned REG_SEL_LSB    = 0;   // a3:a0 register within channel
    localparam int unsigned REG_SEL_W      = 4;
    localparam int unsigned CHAN_SEL_LSB   = 4;   // a6:a4 channel number
    localparam int unsigned CHAN_SEL_W     = 3;
    localparam int unsigned GLOBAL_SEL_BIT = 7;   // a7 global registers
    localparam int unsigned FIFO_DEPTH     = 32;
    localparam int unsigned FIFO_WIDTH     = 17;  // {write, addr, data}
    // feature control bits
    localparam int unsigned FC_TRIG_LSB    = 0;
    localparam int unsigned FC_IR_INV_BIT  = 4;
    localparam int unsigned FC_RS485_BIT   = 5;
    // enhanced feature bits
    localparam int unsigned EF_AUTO_RTS    = 6;
    localparam int unsigned EF_AUTO_CTS    = 7;
    // modem control bits
    localparam int unsigned MC_DTR_BIT     = 0;
    localparam int unsigned MC_RTS_BIT     = 1;
    localparam int unsigned MC_SEL_DTR_BIT = 2;
    // irq enable bits
    localparam int unsigned IE_RTS_BIT     = 6;
    localparam int unsigned IE_CTS_BIT     = 7;
    // reset values
    localparam logic [7:0]  RESET_BYTE     = 8'h00;
    localparam logic [7:0]  DATA_IDLE      = 8'h00;

    typedef enum logic [3:0] {
        BUS_IDLE  = 4'b0001,
        BUS_READ  = 4'b0010,
        BUS_WRITE = 4'b0100,
        BUS_WAIT  = 4'b1000
    } ouhb_state_t;
endpackage : ouhb_pkg

// ---- common/ouhb_stream_if.sv ----
// valid/ready stream carrying captured bus accesses
`timescale 1ns/10ps
`default_nettype none
interface ouhb_stream_if #(parameter int unsigned WIDTH = 17);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface : ouhb_stream_if
`default_nettype wire

// ---- rtl/ouhb_fifo.sv ----
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module ouhb_fifo #(
    parameter int unsigned WIDTH = 17,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic   mclk,
    input  wire logic   reset_n,
    ouhb_stream_if.sink   in_s,
    ouhb_stream_if.source out_s
);
    localparam int unsigned AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_s.ready  = (cnt_q != DEPTH[AW:0]);
    assign out_s.valid = (cnt_q != '0);
    assign out_s.data  = mem_q[rd_q];

    always_comb begin
        push  = in_s.valid && in_s.ready;
        pop   = out_s.valid && out_s.ready;
        wr_d  = push ? wr_q + 1'b1 : wr_q;
        rd_d  = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
        if (push) begin
            mem_q[wr_q] <= in_s.data;
        end
    end
endmodule : ouhb_fifo
`default_nettype wire

// ---- rtl/ouhb_port.sv ----
// host bus port, register access stream and per-channel modem pins
//
// Contract
// - a3:a0 picks one of sixteen registers of the addressed channel.
// - a6:a4 picks channel zero to seven.
// - a7 set routes the access to global registers.
// - style high: read strobe low starts read, device drives addressed byte.
// - style high: write strobe falls to start, rising edge stores the byte.
// - style high: chip select active low gates all strobes.
// - style low: write strobe pin is direction, high read, low write.
// - style low: chip select is the single active-low strobe.
// - interrupt output is open drain, only pulls low.
// - receive input idles high in normal mode.
// - feature control bit four inverts infrared receive pulse.
// - transmit pin carries normal or infrared data per mode.
// - request-to-send usable for automatic flow control.
// - terminal-ready usable for automatic flow control.
// - rs485 mode turns rts or dtr into transmit direction control.
// - clear-to-send and set-ready usable as flow-control inputs.
// - otherwise rts and dtr are active-low general-purpose outputs.
// - carrier detect and ring indicate are active-low general inputs.
// - all eight channels behave alike with their own lines.
`timescale 1ns/10ps
`default_nettype none
module ouhb_port #(
    parameter int unsigned NCH   = ouhb_pkg::NUM_CHAN,
    parameter int unsigned DEPTH = ouhb_pkg::FIFO_DEPTH
) (
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic              bus_style,
    input  wire logic [7:0]        addr,
    input  wire logic [7:0]        data_in,
    output logic [7:0]             data_out,
    output logic                   data_oe,
    input  wire logic              read_strobe_n,
    input  wire logic              write_strobe_n,
    input  wire logic              chip_select_n,
    input  wire logic              irq_req,
    output logic                   irq_n_out,
    output logic                   irq_n_oe,
    output logic                   acc_valid,
    input  wire logic              acc_ready,
    output logic                   acc_write,
    output logic                   acc_global,
    output logic [3:0]             acc_reg,
    output logic [2:0]             acc_chan,
    output logic [7:0]             acc_data,
    input  wire logic [7:0]        rd_data,
    input  wire logic [NCH*8-1:0]  feature_control_reg,
    input  wire logic [NCH*8-1:0]  enhanced_feature_reg,
    input  wire logic [NCH*8-1:0]  modem_control_reg,
    input  wire logic [NCH*8-1:0]  irq_enable_reg,
    input  wire logic [NCH-1:0]    ir_mode,
    input  wire logic [NCH-1:0]    tx_data,
    input  wire logic [NCH-1:0]    tx_ir_data,
    input  wire logic [NCH-1:0]    tx_active,
    input  wire logic [NCH-1:0]    rx_room,
    output logic [NCH-1:0]         rx_data,
    output logic [NCH-1:0]         serial_out,
    input  wire logic [NCH-1:0]    serial_in,
    output logic [NCH-1:0]         request_send_n,
    output logic [NCH-1:0]         terminal_ready_n,
    input  wire logic [NCH-1:0]    clear_send_n,
    input  wire logic [NCH-1:0]    set_ready_n,
    input  wire logic [NCH-1:0]    carrier_detect_n,
    input  wire logic [NCH-1:0]    ring_indicate_n,
    output logic [NCH-1:0]         tx_allowed,
    output logic [NCH*4-1:0]       modem_inputs
);
    import ouhb_pkg::*;

    if (NCH != NUM_CHAN) begin : g_bad_nch
        $error("channel count must be eight for a 3-bit channel field");
    end
    if (DEPTH < 2) begin : g_bad_depth
        $error("fifo depth too small");
    end

    // two-stage synchronisers for the strobes
    logic [2:0] s1_q, s2_q, s3_q;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s1_q <= 3'h7;
            s2_q <= 3'h7;
            s3_q <= 3'h7;
        end else begin
            s1_q <= {chip_select_n, write_strobe_n, read_strobe_n};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    logic cs_n_s, wr_n_s, rd_n_s, cs_n_p, wr_n_p, rd_n_p;
    logic rd_active, wr_active, wr_end, rd_start, m_start, m_end;
    always_comb begin
        {cs_n_s, wr_n_s, rd_n_s} = s2_q;
        {cs_n_p, wr_n_p, rd_n_p} = s3_q;
        rd_active = bus_style ? (!cs_n_s && !rd_n_s)
                              : (!cs_n_s && wr_n_s);
        rd_start  = bus_style ? (!cs_n_s && !rd_n_s && rd_n_p)
                              : (!cs_n_s && cs_n_p && wr_n_s);
        wr_active = bus_style ? (!cs_n_s && !wr_n_s) : (!cs_n_s && !wr_n_s);
        // style high stores on the rising write edge; style low on chip select rise
        // chip select may rise with the strobe, so qualify by the previous sample
        wr_end    = bus_style ? (!cs_n_p && wr_n_s && !wr_n_p)
                              : (cs_n_s && !cs_n_p && !wr_n_s);
        m_start   = rd_start;
        m_end     = !rd_active;
    end

    // access state machine: one access per strobe
    ouhb_state_t st_q, st_d;
    logic [7:0]  dout_q, dout_d;
    logic        oe_q, oe_d;
    logic        push;
    logic        in_ready;
    logic [16:0] push_word;

    always_comb begin
        st_d      = st_q;
        dout_d    = dout_q;
        oe_d      = 1'b0;
        push      = 1'b0;
        push_word = {1'b1, addr, data_in};
        case (st_q)
            BUS_IDLE: begin
                if (m_start) begin
                    st_d = BUS_READ;
                end else if (wr_active) begin
                    st_d = BUS_WRITE;
                end
            end
            BUS_READ: begin
                // addr decoded downstream
                dout_d = rd_data;
                oe_d   = rd_active;
                if (m_end) begin
                    st_d = BUS_IDLE;
                end
            end
            BUS_WRITE: begin
                if (wr_end) begin
                    push = 1'b1;
                    st_d = in_ready ? BUS_IDLE : BUS_WAIT;
                end else if (!wr_active && !(!bus_style && cs_n_s && !cs_n_p)) begin
                    st_d = BUS_IDLE;
                end
            end
            BUS_WAIT: begin
                // fifo full: write is held, not lost
                push = 1'b1;
                if (in_ready) begin
                    st_d = BUS_IDLE;
                end
            end
            default: begin
                st_d = BUS_IDLE;
            end
        endcase
    end

    logic [16:0] hold_q, hold_d;
    always_comb begin
        hold_d = (st_q == BUS_WRITE) ? push_word : hold_q;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_q   <= BUS_IDLE;
            dout_q <= DATA_IDLE;
            oe_q   <= 1'b0;
            hold_q <= '0;
        end else begin
            st_q   <= st_d;
            dout_q <= dout_d;
            oe_q   <= oe_d;
            hold_q <= hold_d;
        end
    end
    assign data_out = dout_q;
    assign data_oe  = oe_q;

    // write accesses pass through a fifo to the register side
    ouhb_stream_if #(.WIDTH(FIFO_WIDTH)) wr_in ();
    ouhb_stream_if #(.WIDTH(FIFO_WIDTH)) wr_out ();
    assign wr_in.valid = push;
    assign wr_in.data  = (st_q == BUS_WAIT) ? hold_q : push_word;
    assign in_ready    = wr_in.ready;

    ouhb_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_fifo (
        .mclk    (mclk),
        .reset_n (reset_n),
        .in_s    (wr_in.sink),
        .out_s   (wr_out.source)
    );

    // output stage register so outputs come from flip-flops
    logic        av_q, av_d;
    logic [16:0] aw_q, aw_d;
    always_comb begin
        av_d         = av_q;
        aw_d         = aw_q;
        wr_out.ready = !av_q || acc_ready;
        if (wr_out.ready) begin
            av_d = wr_out.valid;
            aw_d = wr_out.data;
        end
    end
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            av_q <= 1'b0;
            aw_q <= '0;
        end else begin
            av_q <= av_d;
            aw_q <= aw_d;
        end
    end
    assign acc_valid  = av_q;
    assign acc_write  = aw_q[16];
    assign acc_global = aw_q[8+GLOBAL_SEL_BIT];
    assign acc_chan   = aw_q[8+CHAN_SEL_LSB +: CHAN_SEL_W];
    assign acc_reg    = aw_q[8+REG_SEL_LSB +: REG_SEL_W];
    assign acc_data   = aw_q[7:0];

    // per-channel pins
    function automatic logic bit_of(input logic [NCH*8-1:0] v, input int unsigned ch, input int unsigned b);
        bit_of = v[ch*8+b];
    endfunction : bit_of

    logic [NCH-1:0]   tx_d, rts_d, dtr_d, rx_d, allow_d;
    logic [NCH*4-1:0] mi_d;
    always_comb begin
        for (int unsigned c = 0; c < NCH; c++) begin
            tx_d[c] = ir_mode[c] ? tx_ir_data[c] : tx_data[c];
            rx_d[c] = ir_mode[c] ? (serial_in[c] ^ bit_of(feature_control_reg, c, FC_IR_INV_BIT))
                                 : serial_in[c];
            if (bit_of(feature_control_reg, c, FC_RS485_BIT)) begin
                rts_d[c] = bit_of(modem_control_reg, c, MC_SEL_DTR_BIT) ? !bit_of(modem_control_reg, c, MC_RTS_BIT)
                                                                       : !tx_active[c];
                dtr_d[c] = bit_of(modem_control_reg, c, MC_SEL_DTR_BIT) ? !tx_active[c]
                                                                       : !bit_of(modem_control_reg, c, MC_DTR_BIT);
            end else if (bit_of(enhanced_feature_reg, c, EF_AUTO_RTS)) begin
                // auto flow: deassert when receive side lacks room
                rts_d[c] = !(rx_room[c] && bit_of(modem_control_reg, c, MC_RTS_BIT)
                             && !bit_of(modem_control_reg, c, MC_SEL_DTR_BIT));
                dtr_d[c] = !(rx_room[c] && bit_of(modem_control_reg, c, MC_DTR_BIT)
                             && bit_of(modem_control_reg, c, MC_SEL_DTR_BIT));
            end else begin
                rts_d[c] = !bit_of(modem_control_reg, c, MC_RTS_BIT);
                dtr_d[c] = !bit_of(modem_control_reg, c, MC_DTR_BIT);
            end
            allow_d[c] = !bit_of(enhanced_feature_reg, c, EF_AUTO_CTS)
                       || (bit_of(modem_control_reg, c, MC_SEL_DTR_BIT) ? !set_ready_n[c] : !clear_send_n[c]);
            mi_d[c*4 +: 4] = {!ring_indicate_n[c], !carrier_detect_n[c], !set_ready_n[c], !clear_send_n[c]};
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            serial_out       <= '1;
            request_send_n   <= '1;
            terminal_ready_n <= '1;
            rx_data          <= '1;
            tx_allowed       <= '0;
            modem_inputs     <= '0;
            irq_n_out        <= 1'b0;
            irq_n_oe         <= 1'b0;
        end else begin
            serial_out       <= tx_d;
            request_send_n   <= rts_d;
            terminal_ready_n <= dtr_d;
            rx_data          <= rx_d;
            tx_allowed       <= allow_d;
            modem_inputs     <= mi_d;
            irq_n_out        <= 1'b0;            // only ever pulls low
            irq_n_oe         <= irq_req;
        end
    end
endmodule : ouhb_port
`default_nettype wire

// ---- tb/ouhb_port_sva.sv ----
// concurrent checks on the host port pins and access stream
`timescale 1ns/10ps
`default_nettype none
module ouhb_port_sva #(parameter int unsigned NCH = 8) (
    input wire logic             mclk,
    input wire logic             reset_n,
    input wire logic             read_strobe_n,
    input wire logic             chip_select_n,
    input wire logic             data_oe,
    input wire logic             irq_req,
    input wire logic             irq_n_out,
    input wire logic             irq_n_oe,
    input wire logic             acc_valid,
    input wire logic             acc_ready,
    input wire logic             acc_write,
    input wire logic             acc_global,
    input wire logic [3:0]       acc_reg,
    input wire logic [2:0]       acc_chan,
    input wire logic [7:0]       acc_data,
    input wire logic [NCH*8-1:0] feature_control_reg,
    input wire logic [NCH*8-1:0] enhanced_feature_reg,
    input wire logic [NCH*8-1:0] modem_control_reg,
    input wire logic [NCH-1:0]   ir_mode,
    input wire logic [NCH-1:0]   tx_data,
    input wire logic [NCH-1:0]   tx_ir_data,
    input wire logic [NCH-1:0]   serial_in,
    input wire logic [NCH-1:0]   rx_data,
    input wire logic [NCH-1:0]   serial_out,
    input wire logic [NCH-1:0]   request_send_n,
    input wire logic [NCH-1:0]   terminal_ready_n,
    input wire logic [NCH-1:0]   tx_active,
    input wire logic [NCH-1:0]   rx_room,
    input wire logic [NCH-1:0]   clear_send_n,
    input wire logic [NCH-1:0]   set_ready_n,
    input wire logic [NCH-1:0]   carrier_detect_n,
    input wire logic [NCH-1:0]   ring_indicate_n,
    input wire logic [NCH-1:0]   tx_allowed,
    input wire logic [NCH*4-1:0] modem_inputs
);
    import ouhb_pkg::*;
    logic [NCH-1:0] gp, rts_e, dtr_e, tx_e, rx_e;
    logic [NCH-1:0] rs, au, dsel, allow_e, art_e, adt_e;
    logic [NCH*4-1:0] mi_e;
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        // plain outputs only where neither rs485 nor auto flow owns the pin
        assign gp[c]    = ~feature_control_reg[c*8+FC_RS485_BIT] & ~enhanced_feature_reg[c*8+EF_AUTO_RTS];
        assign rts_e[c] = ~modem_control_reg[c*8+MC_RTS_BIT];
        assign dtr_e[c] = ~modem_control_reg[c*8+MC_DTR_BIT];
        assign rx_e[c]  = serial_in[c] ^ (ir_mode[c] & feature_control_reg[c*8+FC_IR_INV_BIT]);
        assign rs[c]      = feature_control_reg[c*8+FC_RS485_BIT];
        assign au[c]      = ~rs[c] & enhanced_feature_reg[c*8+EF_AUTO_RTS];
        assign dsel[c]    = modem_control_reg[c*8+MC_SEL_DTR_BIT];
        // auto flow holds the pin off while the receiver has no room
        assign art_e[c]   = ~(rx_room[c] & modem_control_reg[c*8+MC_RTS_BIT] & ~dsel[c]);
        assign adt_e[c]   = ~(rx_room[c] & modem_control_reg[c*8+MC_DTR_BIT] & dsel[c]);
        assign allow_e[c] = ~enhanced_feature_reg[c*8+EF_AUTO_CTS] | (dsel[c] ? ~set_ready_n[c] : ~clear_send_n[c]);
        assign mi_e[c*4 +: 4] = ~{ring_indicate_n[c], carrier_detect_n[c], set_ready_n[c], clear_send_n[c]};
    end
    assign tx_e = (ir_mode & tx_ir_data) | (~ir_mode & tx_data);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_irq_drive: assert property (irq_n_out == 1'b0)
        else $error("interrupt pin driven high");
    a_irq_follow: assert property ($past(reset_n) |-> irq_n_oe == $past(irq_req))
        else $error("interrupt pull does not follow request");
    a_tx_select: assert property ($past(reset_n) |-> serial_out == $past(tx_e))
        else $error("transmit pin source wrong");
    a_rx_invert: assert property ($past(reset_n) |-> rx_data == $past(rx_e))
        else $error("receive polarity wrong");
    a_rts_plain: assert property ($past(reset_n) |-> ((request_send_n ^ $past(rts_e)) & $past(gp)) == '0)
        else $error("rts general output wrong");
    a_dtr_plain: assert property ($past(reset_n) |-> ((terminal_ready_n ^ $past(dtr_e)) & $past(gp)) == '0)
        else $error("dtr general output wrong");
    a_oe_idle: assert property ((read_strobe_n && chip_select_n) [*8] |-> !data_oe)
        else $error("data bus driven without read");
    a_rs485_dir: assert property ($past(reset_n) |->
        (((($past(dsel) & terminal_ready_n) | (~$past(dsel) & request_send_n)) ^ ~$past(tx_active)) & $past(rs)) == '0)
        else $error("rs485 direction pin wrong");
    a_auto_flow: assert property ($past(reset_n) |->
        (((request_send_n ^ $past(art_e)) | (terminal_ready_n ^ $past(adt_e))) & $past(au)) == '0)
        else $error("auto flow pin wrong");
    a_cts_gate: assert property ($past(reset_n) |-> tx_allowed == $past(allow_e))
        else $error("transmit permission wrong");
    a_modem_sense: assert property ($past(reset_n) |-> modem_inputs == $past(mi_e))
        else $error("modem input sense wrong");
    a_acc_hold: assert property (acc_valid && !acc_ready |=> acc_valid &&
        $stable({acc_write, acc_global, acc_reg, acc_chan, acc_data}))
        else $error("access word changed while stalled");
    c_push: cover property (acc_valid && acc_ready);
    c_read: cover property ($rose(data_oe));
    c_stall: cover property (acc_valid && !acc_ready [*8]);
endmodule : ouhb_port_sva
bind ouhb_port ouhb_port_sva #(.NCH(NCH)) u_sva (
    .mclk(mclk), .reset_n(reset_n), .read_strobe_n(read_strobe_n), .chip_select_n(chip_select_n),
    .data_oe(data_oe), .irq_req(irq_req), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
    .acc_valid(acc_valid), .acc_ready(acc_ready), .acc_write(acc_write), .acc_global(acc_global),
    .acc_reg(acc_reg), .acc_chan(acc_chan), .acc_data(acc_data), .feature_control_reg(feature_control_reg),
    .enhanced_feature_reg(enhanced_feature_reg), .modem_control_reg(modem_control_reg), .ir_mode(ir_mode),
    .tx_data(tx_data), .tx_ir_data(tx_ir_data), .serial_in(serial_in), .rx_data(rx_data),
    .serial_out(serial_out), .request_send_n(request_send_n), .terminal_ready_n(terminal_ready_n),
    .tx_active(tx_active), .rx_room(rx_room), .clear_send_n(clear_send_n), .set_ready_n(set_ready_n),
    .carrier_detect_n(carrier_detect_n), .ring_indicate_n(ring_indicate_n), .tx_allowed(tx_allowed),
    .modem_inputs(modem_inputs)
);
`default_nettype wire

// ---- tb/ouhb_host_model.sv ----
// host processor model driving the parallel bus in both styles
`timescale 1ns/10ps
`default_nettype none
module ouhb_host_model (
    input  wire logic       mclk,
    input  wire logic [7:0] bus,
    output var logic        bus_style,
    output var logic [7:0]  addr,
    output var logic [7:0]  drive_d,
    output var logic        read_strobe_n,
    output var logic        write_strobe_n,
    output var logic        chip_select_n
);
    initial begin
        {bus_style, read_strobe_n, write_strobe_n, chip_select_n} = 4'hf;
        addr = 8'h00;
        drive_d = 8'h00;
    end
    task automatic access(input logic style, input logic sel, input logic wr, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge mclk);
        bus_style      <= style;
        addr           <= a;
        drive_d        <= wr ? d : ~drive_d; // released bus shows the inverse, not a stale byte
        read_strobe_n  <= 1'b1;
        write_strobe_n <= style | ~wr;
        chip_select_n  <= 1'b1;
        @(posedge mclk);
        chip_select_n  <= ~sel;
        if (style) begin
            read_strobe_n  <= wr;
            write_strobe_n <= ~wr;
        end
        repeat (8) @(posedge mclk);
        q = bus;
        chip_select_n  <= 1'b1;
        read_strobe_n  <= 1'b1;
        write_strobe_n <= style | ~wr;
        repeat (6) @(posedge mclk);
    endtask : access
endmodule : ouhb_host_model
`default_nettype wire

// ---- tb/tb_octal_uart_host_bus_and_modem_pins.sv ----
// self-checking bench for the host port with stream and pin traffic
`timescale 1ns/10ps
`default_nettype none
module tb_octal_uart_host_bus_and_modem_pins;
    import ouhb_pkg::*;
    logic        mclk, reset_n, bus_style, data_oe, rs_n, ws_n, cs_n, irq_req, irq_n_out, irq_n_oe;
    logic        acc_valid, acc_ready, acc_write, acc_global, stall;
    logic [3:0]  acc_reg;
    logic [2:0]  acc_chan;
    logic [7:0]  addr, drive_d, data_out, acc_data, rd_data, bus, serial_out;
    logic [7:0]  ir_mode, tx_d, tx_ir, tx_act, rx_room, ser_in, cts_n, dsr_n, cd_n, ri_n;
    logic [63:0] fc, ef, mc, ie;
    logic [16:0] exp_q[$];
    logic [31:0] r;
    int          seed = 32'h5f7c5abd;
    int          err_count = 0;
    int          n_compared = 0;
    int          cycles = 0;
    assign rd_data = addr ^ 8'h3c;
    assign bus = data_oe ? data_out : drive_d;
    ouhb_host_model host (.mclk(mclk), .bus(bus), .bus_style(bus_style), .addr(addr), .drive_d(drive_d),
        .read_strobe_n(rs_n), .write_strobe_n(ws_n), .chip_select_n(cs_n));
    ouhb_port #(.NCH(8), .DEPTH(32)) uut (.mclk(mclk), .reset_n(reset_n), .bus_style(bus_style), .addr(addr),
        .data_in(bus), .data_out(data_out), .data_oe(data_oe), .read_strobe_n(rs_n), .write_strobe_n(ws_n),
        .chip_select_n(cs_n), .irq_req(irq_req), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
        .acc_valid(acc_valid), .acc_ready(acc_ready), .acc_write(acc_write), .acc_global(acc_global),
        .acc_reg(acc_reg), .acc_chan(acc_chan), .acc_data(acc_data), .rd_data(rd_data),
        .feature_control_reg(fc), .enhanced_feature_reg(ef), .modem_control_reg(mc), .irq_enable_reg(ie),
        .ir_mode(ir_mode), .tx_data(tx_d), .tx_ir_data(tx_ir), .tx_active(tx_act), .rx_room(rx_room),
        .rx_data(), .serial_out(serial_out), .serial_in(ser_in), .request_send_n(), .terminal_ready_n(),
        .clear_send_n(cts_n), .set_ready_n(dsr_n), .carrier_detect_n(cd_n), .ring_indicate_n(ri_n),
        .tx_allowed(), .modem_inputs());
    task automatic report(input logic [16:0] got, input logic [16:0] e);
        err_count++;
        $display("unexpected at %0t: got %h expected %h", $time, got, e);
    endtask : report
    task automatic cmp8(input logic [7:0] got, input logic [7:0] e);
        n_compared++;
        if (got !== e) report({9'h0, got}, {9'h0, e});
    endtask : cmp8
    task automatic cmp_word(input logic [16:0] got);
        logic [16:0] e;
        logic [16:0] m;
        n_compared++;
        e = (exp_q.size() != 0) ? exp_q.pop_front() : ~got;
        // the channel and register fields mean nothing for a global access
        m = e[15] ? 17'h180ff : 17'h1ffff;
        if ((got & m) !== (e & m)) report(got, e);
    endtask : cmp_word
    task automatic op(input logic style, input logic sel, input logic wr, input logic [7:0] a,
                      input logic [7:0] d);
        logic [7:0] q;
        if (wr && sel) exp_q.push_back({1'b1, a[7], a[3:0], a[6:4], d});
        host.access(style, sel, wr, a, d, q);
        if (!wr && sel) cmp8(q, a ^ 8'h3c);
        else if (!wr) cmp8(q, drive_d);
    endtask : op
    task automatic final_report;
        if (err_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        {ir_mode, tx_d, tx_ir, tx_act} <= $random(seed);
        {rx_room, ser_in, cts_n, dsr_n} <= $random(seed);
        {cd_n, ri_n} <= 16'($random(seed));
        irq_req <= 1'($random(seed));
        {fc, ef} <= {$random(seed), $random(seed), $random(seed), $random(seed)};
        {mc, ie} <= {$random(seed), $random(seed), $random(seed), $random(seed)};
        acc_ready <= ~stall & 1'($random(seed));
        if (reset_n && acc_valid && acc_ready) cmp_word({acc_write, acc_global, acc_reg, acc_chan, acc_data});
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        {ir_mode, tx_d, tx_ir, tx_act, rx_room, ser_in, cts_n, dsr_n, cd_n, ri_n} = '0;
        {fc, ef, mc, ie} = '0;
        {irq_req, acc_ready, stall} = 3'b000;
        reset_n = 1'b0;
        repeat (10) @(posedge mclk);
        #1;
        cmp8({6'h0, data_oe, acc_valid}, 8'h00);
        cmp8(serial_out, 8'hff);
        @(posedge mclk);
        reset_n <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            op(r[8], 1'b1, r[9], r[7:0], r[23:16]);
        end
        op(1'b1, 1'b0, 1'b1, 8'h25, 8'ha5);
        op(1'b1, 1'b0, 1'b0, 8'h25, 8'h00);
        stall <= 1'b1;
        // one word more than fifo plus output stage, so the last write waits in hold
        for (int i = 0; i < 34; i++) op(1'b1, 1'b1, 1'b1, 8'(i * 5), 8'(i * 7));
        cmp8({7'h0, acc_valid}, 8'h01);
        stall <= 1'b0;
        for (int i = 0; i < 2000 && exp_q.size() != 0; i++) @(posedge mclk);
        repeat (20) @(posedge mclk);
        cmp8(8'(exp_q.size()), 8'h00);
        final_report();
    end
endmodule : tb_octal_uart_host_bus_and_modem_pins
`default_nettype wire
